// >>> bench/dmda_mem_model.sv
/*
 * Memory and mapped-device model on the far side of the channel's memory port.
 * Assumes requests held until memAck; answers after a selectable wait.
 */
`timescale 1ns/1ps

module dmda_mem_model
    import dmda_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire dmda_mem_t   mem,
    input  wire logic [3:0]  waitCycles,
    output logic             memAck,
    output logic [31:0]      memRdata,
    output logic [31:0]      lastWrAddr,
    output logic [31:0]      lastWrData,
    output int               wrCount
);
    logic [3:0] waitCnt;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            memAck   <= 1'b0;
            waitCnt  <= 4'h0;
            memRdata <= 32'h0;
            wrCount  <= 0;
        end else if (mem.valid && !memAck && waitCnt == waitCycles) begin
            memAck   <= 1'b1;
            waitCnt  <= 4'h0;
            memRdata <= mem.addr ^ 32'h5a5a_0000;
            if (mem.write) begin
                lastWrAddr <= mem.addr;
                lastWrData <= mem.wdata;
                wrCount    <= wrCount + 1;
            end
        end else begin
            // Read data is only good beside the ack; scramble it elsewhere
            memAck   <= 1'b0;
            memRdata <= ~memRdata;
            waitCnt  <= (mem.valid && !memAck) ? waitCnt + 4'h1 : 4'h0;
        end
    end
endmodule : dmda_mem_model

// >>> bench/tb_top.sv
/*
 * Self-checking bench for the descriptor and arbitration block.
 * Assumes the design's default channel base and a single 20 MHz clock.
 */
`timescale 1ns/1ps

module tb_top
    import dmda_pkg::*;
;
    logic                            core_clk;
    logic                            rst_n;
    dmda_bus_t                       regBus;
    logic [31:0]                     regRdata;
    logic                            m2pReq;
    logic                            m2pGnt;
    dmda_mem_t                       memReq;
    logic                            memAck;
    logic [31:0]                     memRdata;
    logic [NUM_M2P-1:0][INT_W-1:0]   m2pIntBits;
    logic [INT_W-1:0]                m2m1IntBits;
    logic                            irq;
    logic [3:0]                      waitCycles;
    logic [31:0]                     lastWrAddr;
    logic [31:0]                     lastWrData;
    int                              wrCount;
    int                              n_errors;
    int                              check_count;
    int                              cycles;
    localparam logic [31:0]          CB = CH_BASE_DEF;

    dmda_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .regBus(regBus),
        .regRdata(regRdata), .m2pReq(m2pReq), .m2pGnt(m2pGnt), .mem(memReq),
        .memAck(memAck), .memRdata(memRdata), .m2pIntBits(m2pIntBits),
        .m2m1IntBits(m2m1IntBits), .irq(irq));

    dmda_mem_model i_mem (.core_clk(core_clk), .rst_n(rst_n), .mem(memReq),
        .waitCycles(waitCycles), .memAck(memAck), .memRdata(memRdata),
        .lastWrAddr(lastWrAddr), .lastWrData(lastWrData), .wrCount(wrCount));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        regBus.wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        regBus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        regBus.rd <= 1'b0;
        @(posedge core_clk);
        d = regRdata;
    endtask : rd

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask : do_reset

    task automatic t_xfer();
        logic [31:0] d;
        waitCycles <= 4'h3;
        wr(CB + OFF_SB0, 32'h0000_1000);
        wr(CB + OFF_DB0, 32'h0000_2000);
        wr(CB + OFF_BC0, 32'h0000_0008);
        rd(CB + OFF_SC0, d);
        chk("srcCur0 load", d, 32'h0000_1000);
        rd(CB + OFF_DC0, d);
        chk("dstCur0 load", d, 32'h0000_2000);
        wr(CB + OFF_IMASK, 32'h0000_0003);
        wr(CB + OFF_CTRL, 32'h0000_0003);
        // Refill the idle descriptor while buffer 0 is moving
        wr(CB + OFF_SB1, 32'h0000_3000);
        wr(CB + OFF_DB1, 32'h0000_4000);
        wr(CB + OFF_BC1, 32'h0000_0004);
        rd(CB + OFF_SB0, d);
        chk("srcBase0 kept", d, 32'h0000_1000);
        d = 32'h0;
        for (int i = 0; i < 60 && d[INT_DONE] !== 1'b1; i++) begin
            rd(CB + OFF_ISTAT, d);
        end
        chk("status after both", d, 32'h0000_0003);
        rd(CB + OFF_SC0, d);
        chk("srcCur0 end", d, 32'h0000_1008);
        rd(CB + OFF_DC0, d);
        chk("dstCur0 end", d, 32'h0000_2008);
        rd(CB + OFF_SC1, d);
        chk("srcCur1 end", d, 32'h0000_3004);
        rd(CB + OFF_DC1, d);
        chk("dstCur1 end", d, 32'h0000_4004);
        chk("last write addr", lastWrAddr, 32'h0000_4000);
        chk("last write data", lastWrData, 32'h5a5a_3000);
        chk("write count", wrCount, 32'h0000_0003);
        chk("irq set", {31'h0, irq}, 32'h1);
        rd(ADDR_GIS, d);
        chk("summary own", d, 32'h0000_0400);
        wr(CB + OFF_IMASK, 32'h0000_0000);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(CB + OFF_ISTAT, 32'h0000_0003);
        rd(CB + OFF_ISTAT, d);
        chk("status cleared", d, 32'h0);
        rd(ADDR_GIS, d);
        chk("summary cleared", d, 32'h0);
        // Reuse buffer 0 by its count alone; it takes over from buffer 1
        wr(CB + OFF_BC0, 32'h0000_0008);
        rd(CB + OFF_SC0, d);
        chk("srcCur0 reuse", d, 32'h0000_1000);
        rd(CB + OFF_STAT, d);
        chk("reuse active", {31'h0, d[2]}, 32'h0);
        $display("test xfer done");
    endtask : t_xfer

    task automatic t_zero();
        logic [31:0] d;
        logic        seen;
        do_reset();
        seen = 1'b0;
        wr(CB + OFF_BC0, 32'h0000_0000);
        wr(CB + OFF_CTRL, 32'h0000_0003);
        repeat (20) begin
            @(posedge core_clk);
            seen = seen | memReq.valid;
        end
        chk("zero count moves", {31'h0, seen}, 32'h0);
        rd(CB + OFF_STAT, d);
        chk("zero count state", {30'h0, d[4:3]}, 32'h1);
        $display("test zero done");
    endtask : t_zero

    task automatic t_summary();
        logic [31:0] d;
        logic [NUM_M2P-1:0][INT_W-1:0] v;
        for (int c = 0; c < NUM_M2P; c++) begin
            v = '0;
            v[c] = 2'b10;
            m2pIntBits <= v;
            rd(ADDR_GIS, d);
            chk("summary periph", d, 32'h1 << (c ^ 1));
        end
        m2pIntBits <= '0;
        m2m1IntBits <= 2'b01;
        rd(ADDR_GIS, d);
        chk("summary m2m1", d, 32'h0000_0800);
        m2m1IntBits <= 2'b11;
        wr(ADDR_GIS, 32'hffff_ffff);
        rd(ADDR_GIS, d);
        chk("summary ro", d, 32'h0000_0800);
        m2m1IntBits <= 2'b00;
        rd(ADDR_GIS, d);
        chk("summary or", d, 32'h0);
        rd(32'h8000_0390, d);
        chk("unmapped", d, 32'h0);
        $display("test summary done");
    endtask : t_summary

    task automatic t_arb();
        logic [31:0] d;
        logic        low;
        do_reset();
        waitCycles <= 4'h0;
        rd(ADDR_PRIO, d);
        chk("prio reset", d, 32'h0);
        m2pReq <= 1'b1;
        wr(CB + OFF_SB0, 32'h0000_5000);
        wr(CB + OFF_DB0, 32'h0000_6000);
        wr(CB + OFF_BC0, 32'h0000_0004);
        wr(CB + OFF_CTRL, 32'h0000_0003);
        repeat (10) @(posedge core_clk);
        chk("periph first valid", {31'h0, memReq.valid}, 32'h0);
        chk("periph first gnt", {31'h0, m2pGnt}, 32'h1);
        wr(ADDR_PRIO, 32'h0000_0001);
        low = 1'b0;
        // The grant drops only in the cycle before the request goes out
        for (int i = 0; i < 20 && memReq.valid !== 1'b1; i++) begin
            low = low | (m2pGnt === 1'b0);
            @(posedge core_clk);
        end
        chk("m2m wins valid", {31'h0, memReq.valid}, 32'h1);
        chk("m2m wins gnt", {31'h0, low}, 32'h1);
        m2pReq <= 1'b0;
        rd(ADDR_PRIO, d);
        chk("prio readback", d, 32'h1);
        $display("test arb done");
    endtask : t_arb

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    initial begin
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        rst_n = 1'b0;
        regBus = '0;
        m2pReq = 1'b0;
        m2pIntBits = '0;
        m2m1IntBits = '0;
        waitCycles = 4'h0;
        do_reset();
        t_xfer();
        t_summary();
        t_zero();
        t_arb();
        end_of_test();
    end
endmodule : tb_top

// >>> design/dmda_core.sv
/*
 * One mem_to_mem channel with double-buffered descriptors, the global
 * interrupt summary and the group priority arbiter.
 * Assumes a memory port that holds a request until it acks, and
 * interrupt register bits of the other channels from the same clock.
 */
// Contract
// - Idle descriptor writable without disturbing transfer
// - Count write loads source pointer, activates buffer unless current one pending
// - Count write loads destination pointer
// - Source pointer keeps post-incremented end address
// - Destination pointer live, keeps post-incremented end
// - Summary bit is OR of channel interrupts
// - Summary stores nothing, clears with channel
// - Summary read-only, upper bits reserved
// - Bit 11 channel one, bit 10 zero
// - Peripheral summary bits pair-swapped
// - Priority bit resets zero, peripherals first
// - Count write alone reuses a descriptor
// - Zero count at trigger stays stalled
`timescale 1ns/1ps

module dmda_core
    import dmda_pkg::*;
#(
    parameter logic [31:0] CH_BASE  = CH_BASE_DEF,
    parameter int          CH_INT_W = INT_W
) (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire dmda_bus_t                         regBus,
    output logic [31:0]                            regRdata,
    input  wire logic                              m2pReq,
    output logic                                   m2pGnt,
    output dmda_mem_t                              mem,
    input  wire logic                              memAck,
    input  wire logic [31:0]                       memRdata,
    input  wire logic [NUM_M2P-1:0][CH_INT_W-1:0]  m2pIntBits,
    input  wire logic [CH_INT_W-1:0]               m2m1IntBits,
    output logic                                   irq
);

    dmda_state_t       st_reg;
    dmda_state_t       st_next;
    logic              m2mReq;
    logic              m2mGnt;
    logic [GIS_W-1:0]  summary;
    logic              a;

    assign a = st_reg.active;

    // Address match within the channel window
    function automatic logic hit(input logic [31:0] adr, input logic [31:0] off);
        hit = (adr == (CH_BASE + off));
    endfunction : hit

    // Group arbiter between peripheral channels and this channel
    assign m2mReq = ((st_reg.fsm == DMDA_MEM_RD) || (st_reg.fsm == DMDA_MEM_WR))
                    && !st_reg.mem.valid;
    assign m2mGnt = m2mReq && (!m2pReq || st_reg.prioSwap);
    assign m2pGnt = m2pReq && !(m2mReq && st_reg.prioSwap);

    // Global summary: combinational, no storage
    genvar gi;
    generate
        for (gi = 0; gi < NUM_M2P; gi++) begin : g_sum
            assign summary[gi] = |m2pIntBits[gi ^ 1];
        end
    endgenerate
    assign summary[GIS_M2M0] = |st_reg.intStat;
    assign summary[GIS_M2M1] = |m2m1IntBits;

    always_comb begin
        logic [INT_W-1:0] setEv;
        logic [INT_W-1:0] clrEv;
        logic             nb;
        setEv   = '0;
        clrEv   = '0;
        nb      = 1'b0;
        st_next = st_reg;
        st_next.rdata = '0;

        // Register writes
        if (regBus.wr) begin
            if (hit(regBus.addr, OFF_CTRL)) begin
                st_next.enable = regBus.wdata[CTRL_EN];
                st_next.start  = regBus.wdata[CTRL_START];
            end
            if (hit(regBus.addr, OFF_ISTAT)) begin
                clrEv = regBus.wdata[INT_W-1:0];
            end
            if (hit(regBus.addr, OFF_IMASK)) begin
                st_next.intMask = regBus.wdata[INT_W-1:0];
            end
            // Base writes touch only their own descriptor
            if (hit(regBus.addr, OFF_SB0)) begin
                st_next.srcBase[0] = regBus.wdata;
            end
            if (hit(regBus.addr, OFF_SB1)) begin
                st_next.srcBase[1] = regBus.wdata;
            end
            if (hit(regBus.addr, OFF_DB0)) begin
                st_next.dstBase[0] = regBus.wdata;
            end
            if (hit(regBus.addr, OFF_DB1)) begin
                st_next.dstBase[1] = regBus.wdata;
            end
            for (int b = 0; b < 2; b++) begin
                if (hit(regBus.addr, (b == 0) ? OFF_BC0 : OFF_BC1)) begin
                    st_next.cnt[b]    = regBus.wdata[CNT_W-1:0];
                    st_next.srcCur[b] = st_reg.srcBase[b];
                    st_next.dstCur[b] = st_reg.dstBase[b];
                    st_next.pend[b]   = 1'b1;
                    if (!st_reg.pend[a]) begin
                        st_next.active = b[0];
                    end
                end
            end
            if (regBus.addr == ADDR_PRIO) begin
                st_next.prioSwap = regBus.wdata[PRIO_BIT];
            end
        end

        // Register reads, answered next cycle
        if (regBus.rd) begin
            if (hit(regBus.addr, OFF_CTRL)) begin
                st_next.rdata[CTRL_EN]    = st_reg.enable;
                st_next.rdata[CTRL_START] = st_reg.start;
            end
            if (hit(regBus.addr, OFF_ISTAT)) begin
                st_next.rdata[INT_W-1:0] = st_reg.intStat;
            end
            if (hit(regBus.addr, OFF_IMASK)) begin
                st_next.rdata[INT_W-1:0] = st_reg.intMask;
            end
            if (hit(regBus.addr, OFF_STAT)) begin
                st_next.rdata[4:0] = {st_reg.fsm, st_reg.active, st_reg.pend};
            end
            if (hit(regBus.addr, OFF_BC0)) begin
                st_next.rdata[CNT_W-1:0] = st_reg.cnt[0];
            end
            if (hit(regBus.addr, OFF_BC1)) begin
                st_next.rdata[CNT_W-1:0] = st_reg.cnt[1];
            end
            if (hit(regBus.addr, OFF_SB0)) begin
                st_next.rdata = st_reg.srcBase[0];
            end
            if (hit(regBus.addr, OFF_SB1)) begin
                st_next.rdata = st_reg.srcBase[1];
            end
            if (hit(regBus.addr, OFF_SC0)) begin
                st_next.rdata = st_reg.srcCur[0];
            end
            if (hit(regBus.addr, OFF_SC1)) begin
                st_next.rdata = st_reg.srcCur[1];
            end
            if (hit(regBus.addr, OFF_DB0)) begin
                st_next.rdata = st_reg.dstBase[0];
            end
            if (hit(regBus.addr, OFF_DB1)) begin
                st_next.rdata = st_reg.dstBase[1];
            end
            if (hit(regBus.addr, OFF_DC0)) begin
                st_next.rdata = st_reg.dstCur[0];
            end
            if (hit(regBus.addr, OFF_DC1)) begin
                st_next.rdata = st_reg.dstCur[1];
            end
            if (regBus.addr == ADDR_PRIO) begin
                st_next.rdata[PRIO_BIT] = st_reg.prioSwap;
            end
            if (regBus.addr == ADDR_GIS) begin
                st_next.rdata[GIS_W-1:0] = summary;
            end
        end

        // Transfer engine
        unique case (st_reg.fsm)
            DMDA_IDLE: begin
                if (st_reg.enable) begin
                    st_next.fsm = DMDA_STALL;
                end
            end
            DMDA_STALL: begin
                if (!st_reg.enable) begin
                    st_next.fsm = DMDA_IDLE;
                end else if (st_reg.start && st_reg.pend[a]
                             && (st_reg.cnt[a] != '0)) begin
                    st_next.fsm = DMDA_MEM_RD;
                end
            end
            DMDA_MEM_RD: begin
                if (m2mGnt) begin
                    st_next.mem.valid = 1'b1;
                    st_next.mem.write = 1'b0;
                    st_next.mem.addr  = st_reg.srcCur[a];
                end
                if (st_reg.mem.valid && memAck) begin
                    st_next.mem.valid = 1'b0;
                    st_next.data      = memRdata;
                    st_next.srcCur[a] = st_reg.srcCur[a] + ADDR_STEP;
                    st_next.fsm       = DMDA_MEM_WR;
                end
            end
            DMDA_MEM_WR: begin
                if (m2mGnt) begin
                    st_next.mem.valid = 1'b1;
                    st_next.mem.write = 1'b1;
                    st_next.mem.addr  = st_reg.dstCur[a];
                    st_next.mem.wdata = st_reg.data;
                end
                if (st_reg.mem.valid && memAck) begin
                    st_next.mem.valid = 1'b0;
                    st_next.dstCur[a] = st_reg.dstCur[a] + ADDR_STEP;
                    if (st_reg.cnt[a] > CNT_STEP) begin
                        st_next.cnt[a] = st_reg.cnt[a] - CNT_STEP;
                        st_next.fsm    = DMDA_MEM_RD;
                    end else begin
                        st_next.cnt[a]  = '0;
                        st_next.pend[a] = 1'b0;
                        nb = ~a;
                        if (st_reg.pend[nb] && (st_reg.cnt[nb] != '0)) begin
                            // Switch to the other buffer
                            st_next.active   = nb;
                            setEv[INT_NFB]   = 1'b1;
                            st_next.fsm      = DMDA_MEM_RD;
                        end else begin
                            setEv[INT_DONE] = 1'b1;
                            st_next.start   = 1'b0;
                            st_next.fsm     = DMDA_STALL;
                        end
                    end
                end
            end
        endcase

        // Sticky status: a set in the clearing cycle wins
        st_next.intStat = (st_reg.intStat & ~clrEv) | setEv;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdata = st_reg.rdata;
    assign mem      = st_reg.mem;
    assign irq      = |(st_reg.intStat & st_reg.intMask);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_bc_src;
        regBus.wr && hit(regBus.addr, OFF_BC0) && !regBus.rd
            |=> st_reg.srcCur[0] == $past(st_reg.srcBase[0]);
    endproperty
    a_bc_src: assert property (p_bc_src) else $error("source pointer not loaded");

    property p_bc_dst;
        regBus.wr && hit(regBus.addr, OFF_BC1)
            |=> st_reg.dstCur[1] == $past(st_reg.dstBase[1]) && st_reg.pend[1];
    endproperty
    a_bc_dst: assert property (p_bc_dst) else $error("dest pointer not loaded");

    property p_idle_wr;
        regBus.wr && hit(regBus.addr, a ? OFF_SB0 : OFF_SB1)
            && st_reg.fsm == DMDA_MEM_WR && !memAck
            |=> $stable(st_reg.srcCur) && $stable(st_reg.active);
    endproperty
    a_idle_wr: assert property (p_idle_wr) else $error("active buffer disturbed");

    property p_src_inc;
        st_reg.fsm == DMDA_MEM_RD && st_reg.mem.valid && memAck && !regBus.wr
            |=> st_reg.srcCur[$past(a)] == $past(st_reg.srcCur[a]) + ADDR_STEP;
    endproperty
    a_src_inc: assert property (p_src_inc) else $error("source not incremented");

    property p_gis;
        regBus.rd && regBus.addr == ADDR_GIS
            |=> regRdata[GIS_M2M0] == $past(|st_reg.intStat)
                && regRdata[0] == $past(|m2pIntBits[1])
                && regRdata[31:GIS_W] == '0;
    endproperty
    a_gis: assert property (p_gis) else $error("summary read wrong");

    property p_prio_m2p;
        m2pReq && m2mReq && !st_reg.prioSwap |-> m2pGnt && !m2mGnt;
    endproperty
    a_prio_m2p: assert property (p_prio_m2p) else $error("peripheral not first");

    property p_prio_m2m;
        m2pReq && m2mReq && st_reg.prioSwap |-> m2mGnt && !m2pGnt ##1 mem.valid;
    endproperty
    a_prio_m2m: assert property (p_prio_m2m) else $error("mem_to_mem not first");

    property p_zero_stall;
        st_reg.fsm == DMDA_STALL && st_reg.cnt[a] == '0 && !regBus.wr
            |=> st_reg.fsm != DMDA_MEM_RD;
    endproperty
    a_zero_stall: assert property (p_zero_stall) else $error("zero count moved");

    property p_sum_clr;
        st_reg.intStat == '0 ##1 regBus.rd && regBus.addr == ADDR_GIS
            && $stable(st_reg.intStat) |=> !regRdata[GIS_M2M0];
    endproperty
    a_sum_clr: assert property (p_sum_clr) else $error("summary kept stale bit");

    property p_bc_src1;
        regBus.wr && hit(regBus.addr, OFF_BC1) && !a
            |=> st_reg.srcCur[1] == $past(st_reg.srcBase[1]);
    endproperty
    a_bc_src1: assert property (p_bc_src1) else $error("source 1 not loaded");

    property p_bc_dst0;
        regBus.wr && hit(regBus.addr, OFF_BC0) && st_reg.fsm != DMDA_MEM_WR
            |=> st_reg.dstCur[0] == $past(st_reg.dstBase[0]) && st_reg.pend[0];
    endproperty
    a_bc_dst0: assert property (p_bc_dst0) else $error("dest 0 not loaded");

    property p_bc_act;
        regBus.wr && (hit(regBus.addr, OFF_BC0) || hit(regBus.addr, OFF_BC1))
            && !st_reg.pend[a] && st_reg.fsm != DMDA_MEM_WR
            |=> st_reg.active == $past(hit(regBus.addr, OFF_BC1));
    endproperty
    a_bc_act: assert property (p_bc_act) else $error("written buffer not active");

    property p_dst_inc;
        st_reg.fsm == DMDA_MEM_WR && st_reg.mem.valid && memAck && !regBus.wr
            |=> st_reg.dstCur[$past(a)] == $past(st_reg.dstCur[a]) + ADDR_STEP;
    endproperty
    a_dst_inc: assert property (p_dst_inc) else $error("dest not incremented");

    property p_gis_hi;
        regBus.rd && regBus.addr == ADDR_GIS
            |=> regRdata[GIS_M2M1] == $past(|m2m1IntBits)
                && regRdata[GIS_M2M0 - 1] == $past(|m2pIntBits[NUM_M2P - 2]);
    endproperty
    a_gis_hi: assert property (p_gis_hi) else $error("summary high bits wrong");

    property p_gis_ro;
        regBus.wr && regBus.addr == ADDR_GIS && st_reg.fsm != DMDA_MEM_WR
            |=> $stable(st_reg.intStat) && $stable(st_reg.prioSwap);
    endproperty
    a_gis_ro: assert property (p_gis_ro) else $error("summary write took effect");

    property p_prio_rst;
        !$past(rst_n) |-> !st_reg.prioSwap;
    endproperty
    a_prio_rst: assert property (p_prio_rst) else $error("priority bit not reset");

    property p_prio_wr;
        regBus.wr && regBus.addr == ADDR_PRIO
            |=> st_reg.prioSwap == $past(regBus.wdata[PRIO_BIT]);
    endproperty
    a_prio_wr: assert property (p_prio_wr) else $error("priority bit not written");

    property p_stall_go;
        st_reg.fsm == DMDA_STALL && st_reg.enable && st_reg.start
            && st_reg.pend[a] && st_reg.cnt[a] != '0
            |=> st_reg.fsm == DMDA_MEM_RD;
    endproperty
    a_stall_go: assert property (p_stall_go) else $error("buffer did not start");

    property p_m2p_free;
        m2pReq && !m2mReq |-> m2pGnt && !m2mGnt;
    endproperty
    a_m2p_free: assert property (p_m2p_free) else $error("peripherals blocked");

endmodule : dmda_core

// >>> design/dmda_pkg.sv
/*
 * Shared constants and types for the mem_to_mem descriptor and arbitration block.
 * Assumes a single core clock domain and a plain strobe register port.
 */
package dmda_pkg;

    // Channel register offsets, relative to the channel base
    localparam logic [31:0] OFF_CTRL  = 32'h0000_0000;
    localparam logic [31:0] OFF_ISTAT = 32'h0000_0004;
    localparam logic [31:0] OFF_IMASK = 32'h0000_0008;
    localparam logic [31:0] OFF_STAT  = 32'h0000_000c;
    localparam logic [31:0] OFF_BC0   = 32'h0000_0010;
    localparam logic [31:0] OFF_BC1   = 32'h0000_0014;
    localparam logic [31:0] OFF_SB0   = 32'h0000_0018;
    localparam logic [31:0] OFF_SB1   = 32'h0000_001c;
    localparam logic [31:0] OFF_SC0   = 32'h0000_0024;
    localparam logic [31:0] OFF_SC1   = 32'h0000_0028;
    localparam logic [31:0] OFF_DB0   = 32'h0000_002c;
    localparam logic [31:0] OFF_DB1   = 32'h0000_0030;
    localparam logic [31:0] OFF_DC1   = 32'h0000_003c;
    localparam logic [31:0] OFF_DC0   = 32'h0000_0044;

    // Global registers at absolute addresses
    localparam logic [31:0] ADDR_PRIO = 32'h8000_0380;
    localparam logic [31:0] ADDR_GIS  = 32'h8000_03c0;
    localparam logic [31:0] CH_BASE_DEF = 32'h8000_0000;

    // Field positions
    localparam int CTRL_EN    = 0;
    localparam int CTRL_START = 1;
    localparam int INT_DONE   = 0;
    localparam int INT_NFB    = 1;
    localparam int PRIO_BIT   = 0;
    localparam int GIS_M2M1   = 11;
    localparam int GIS_M2M0   = 10;

    localparam int NUM_M2P = 10;
    localparam int GIS_W   = 12;
    localparam int INT_W   = 2;
    localparam int CNT_W   = 16;

    // One word moves per read/write pair
    localparam logic [31:0]      ADDR_STEP = 32'h0000_0004;
    localparam logic [CNT_W-1:0] CNT_STEP  = 16'h0004;

    typedef enum logic [1:0] {
        DMDA_IDLE, DMDA_STALL, DMDA_MEM_RD, DMDA_MEM_WR
    } dmda_fsm_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dmda_bus_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dmda_mem_t;

    typedef struct packed {
        dmda_fsm_t                fsm;
        logic                     active;
        logic [1:0]               pend;
        logic [1:0][31:0]         srcBase;
        logic [1:0][31:0]         dstBase;
        logic [1:0][31:0]         srcCur;
        logic [1:0][31:0]         dstCur;
        logic [1:0][CNT_W-1:0]    cnt;
        logic [31:0]              data;
        logic                     enable;
        logic                     start;
        logic                     prioSwap;
        logic [INT_W-1:0]         intStat;
        logic [INT_W-1:0]         intMask;
        dmda_mem_t                mem;
        logic [31:0]              rdata;
    } dmda_state_t;

endpackage : dmda_pkg
